/* File: logic/boot_seq.sv */
// Boot sequencer: reset release, CPU stall, host boot, ROM copy, host access decode
// Functional notes
// - Held in reset while reset pin low
// - Host boot stalls CPU, releases rest
// - Host reaches all memory while stalled
// - Interrupt bit ends stall, fetch at zero
// - Boot-ending interrupt never pends at CPU
// - Interrupt bit releases stall only in host boot
// - No further interrupts until CPU clears bit
// - Memory boot copies 1K from region one
// - ROM bytes assembled into 32-bit words
// - Copy is one single-frame block transfer
// - Copy done releases stall, fetch at zero
// - No boot starts at zero, no stall
// - Internal memory at zero, 256K
// - External memory four 256M regions upward
// - 256K window routes to memory interface registers
`timescale 1ns/10ps
`default_nettype none
module boot_seq #(
	parameter int ROM_BYTES = boot_pkg::ROM_IMAGE_BYTES
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_reset_n,
	input  wire logic [1:0]        i_boot_mode,
	input  wire logic              i_big_endian,
	input  wire logic              i_hint_set,
	input  wire logic              i_cpu_hint_clr,
	input  wire logic              i_host_req,
	input  wire logic              i_host_we,
	input  wire logic [31:0]       i_host_addr,
	input  wire logic [31:0]       i_host_wdata,
	input  wire logic              i_rom_ack,
	input  wire logic [7:0]        i_rom_data,
	output var  logic              o_periph_rst,
	output var  logic              o_cpu_stall,
	output var  logic              o_cpu_go,
	output var  logic [31:0]       o_cpu_start_addr,
	output var  logic              o_hint_flag,
	output var  logic              o_cpu_int,
	output var  logic              o_bus_valid,
	output var  logic              o_bus_we,
	output var  boot_pkg::region_t o_bus_region,
	output var  logic [31:0]       o_bus_offset,
	output var  logic [31:0]       o_bus_wdata,
	output var  logic              o_rom_req,
	output var  logic [31:0]       o_rom_addr,
	output var  logic              o_rom_default_timing,
	output var  logic              o_mem_wr,
	output var  logic [31:0]       o_mem_addr,
	output var  logic [31:0]       o_mem_wdata,
	output var  logic              o_copy_done
);
	import boot_pkg::*;

	localparam int CNT_W = $clog2(ROM_BYTES) + 1;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_HOST_WAIT,
		ST_COPY,
		ST_RUN
	} state_t;

	// ============================================================
	// Pin synchronisers
	logic [1:0] rstn_sync_r;
	logic [1:0] mode_s1_r;
	logic [1:0] mode_s2_r;
	logic [1:0] endian_sync_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rstn_sync_r   <= 2'h0;
			mode_s1_r     <= BOOT_MODE_RST;
			mode_s2_r     <= BOOT_MODE_RST;
			endian_sync_r <= 2'h0;
		end else begin
			rstn_sync_r   <= {rstn_sync_r[0], i_reset_n};
			mode_s1_r     <= i_boot_mode;
			mode_s2_r     <= mode_s1_r;
			endian_sync_r <= {endian_sync_r[0], i_big_endian};
		end
	end

	logic dev_rst;
	assign dev_rst = i_rst | ~rstn_sync_r[1];

	// ============================================================
	// Boot state
	state_t             state_r;
	logic [1:0]         mode_r;
	logic               big_endian_r;
	logic [CNT_W-1:0]   byte_cnt_r;
	logic [1:0]         lane_r;
	logic [31:0]        word_r;
	logic               hint_accept;
	logic               copy_last;

	assign hint_accept = i_hint_set & ~o_hint_flag;
	assign copy_last   = (state_r == ST_COPY) && o_rom_req && i_rom_ack
		&& (byte_cnt_r == CNT_W'(ROM_BYTES - 1));

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			state_r      <= ST_RESET;
			mode_r       <= BOOT_MODE_RST;
			big_endian_r <= 1'b0;
		end else begin
			case (state_r)
				ST_RESET: begin
					mode_r       <= mode_s2_r;
					big_endian_r <= endian_sync_r[1];
					case (mode_s2_r)
						BOOT_HOST: state_r <= ST_HOST_WAIT;
						BOOT_EMIF: state_r <= ST_COPY;
						default:   state_r <= ST_RUN;
					endcase
				end
				ST_HOST_WAIT: begin
					if (hint_accept && mode_r == BOOT_HOST) begin
						state_r <= ST_RUN;
					end
				end
				ST_COPY: begin
					if (copy_last) begin
						state_r <= ST_RUN;
					end
				end
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// ============================================================
	// CPU control
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_periph_rst     <= 1'b1;
			o_cpu_stall      <= 1'b1;
			o_cpu_go         <= 1'b0;
			o_cpu_start_addr <= CPU_START_ADDR;
		end else begin
			o_periph_rst     <= 1'b0;
			o_cpu_start_addr <= CPU_START_ADDR;
			o_cpu_go         <= 1'b0;
			if (state_r == ST_RESET && mode_s2_r != BOOT_HOST && mode_s2_r != BOOT_EMIF) begin
				o_cpu_stall <= 1'b0;
				o_cpu_go    <= 1'b1;
			end else if (state_r == ST_HOST_WAIT && hint_accept) begin
				o_cpu_stall <= 1'b0;
				o_cpu_go    <= 1'b1;
			end else if (copy_last) begin
				o_cpu_stall <= 1'b0;
				o_cpu_go    <= 1'b1;
			end
		end
	end

	// ============================================================
	// Host-to-CPU interrupt bit
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_hint_flag <= 1'b0;
			o_cpu_int   <= 1'b0;
		end else begin
			// Set wins over a clear in the same cycle
			if (i_hint_set) begin
				o_hint_flag <= 1'b1;
			end else if (i_cpu_hint_clr && state_r == ST_RUN) begin
				o_hint_flag <= 1'b0;
			end
			// Only a set seen by a running CPU pends
			o_cpu_int <= hint_accept && state_r == ST_RUN && !o_cpu_stall;
		end
	end

	// ============================================================
	// Boot copy engine
	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			byte_cnt_r           <= '0;
			lane_r               <= 2'h0;
			word_r               <= 32'h0000_0000;
			o_rom_req            <= 1'b0;
			o_rom_addr           <= ROM_BASE_ADDR;
			o_rom_default_timing <= 1'b0;
			o_mem_wr             <= 1'b0;
			o_mem_addr           <= COPY_DEST_ADDR;
			o_mem_wdata          <= 32'h0000_0000;
			o_copy_done          <= 1'b0;
		end else begin
			o_mem_wr <= 1'b0;
			if (state_r == ST_RESET) begin
				o_rom_req            <= mode_s2_r == BOOT_EMIF;
				o_rom_default_timing <= mode_s2_r == BOOT_EMIF;
				o_rom_addr           <= ROM_BASE_ADDR;
			end else if (state_r == ST_COPY && o_rom_req && i_rom_ack) begin
				// Byte order follows the system
				if (big_endian_r) begin
					word_r[8*(3-lane_r) +: 8] <= i_rom_data;
				end else begin
					word_r[8*lane_r +: 8] <= i_rom_data;
				end
				lane_r     <= lane_r + 2'h1;
				byte_cnt_r <= byte_cnt_r + CNT_W'(1);
				o_rom_addr <= o_rom_addr + 32'h0000_0001;
				if (lane_r == 2'h3) begin
					o_mem_wr   <= 1'b1;
					o_mem_addr <= COPY_DEST_ADDR + 32'(byte_cnt_r & ~CNT_W'(3));
					if (big_endian_r) begin
						o_mem_wdata <= {word_r[31:8], i_rom_data};
					end else begin
						o_mem_wdata <= {i_rom_data, word_r[23:0]};
					end
				end
				if (copy_last) begin
					o_rom_req            <= 1'b0;
					o_rom_default_timing <= 1'b0;
					o_copy_done          <= 1'b1;
				end
			end
		end
	end

	// ============================================================
	// Host access path through the address decoder
	logic host_ok;
	assign host_ok = i_host_req && state_r != ST_RESET;

	addr_decode u_decode (
		.i_clk    (i_clk),
		.i_rst    (dev_rst),
		.i_valid  (host_ok),
		.i_addr   (i_host_addr),
		.o_valid  (o_bus_valid),
		.o_region (o_bus_region),
		.o_offset (o_bus_offset)
	);

	always_ff @(posedge i_clk) begin
		if (dev_rst) begin
			o_bus_we    <= 1'b0;
			o_bus_wdata <= 32'h0000_0000;
		end else begin
			o_bus_we    <= host_ok & i_host_we;
			o_bus_wdata <= i_host_wdata;
		end
	end

	// ============================================================
	// Checks
	a_reset_holds_stall: assert property (@(posedge i_clk)
		!rstn_sync_r[1] |=> o_cpu_stall && o_periph_rst)
		else $error("stall not held during reset");
	a_host_boot_stall: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r == ST_HOST_WAIT |-> o_cpu_stall && !o_periph_rst)
		else $error("host boot must stall cpu only");
	a_hint_release: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r == ST_HOST_WAIT && i_hint_set && !o_hint_flag |=> !o_cpu_stall && o_cpu_go
		&& o_cpu_start_addr == 32'h0000_0000)
		else $error("interrupt bit did not release stall");
	a_no_boot_int: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r == ST_HOST_WAIT |=> !o_cpu_int)
		else $error("boot interrupt pended at cpu");
	a_hint_mode_only: assert property (@(posedge i_clk) disable iff (dev_rst)
		$fell(o_cpu_stall) && $past(state_r) == ST_HOST_WAIT |-> mode_r == BOOT_HOST)
		else $error("stall released outside host boot");
	a_hint_blocked: assert property (@(posedge i_clk) disable iff (dev_rst)
		o_hint_flag && !i_cpu_hint_clr |=> !o_cpu_int)
		else $error("interrupt accepted while bit set");
	a_copy_stall: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r == ST_COPY |-> o_cpu_stall && o_rom_default_timing)
		else $error("copy without stall or rom timing");
	a_word_assemble: assert property (@(posedge i_clk) disable iff (dev_rst)
		o_mem_wr |-> o_mem_addr[1:0] == 2'h0 && $past(lane_r) == 2'h3)
		else $error("word written before four bytes");
	a_copy_release: assert property (@(posedge i_clk) disable iff (dev_rst)
		copy_last |=> !o_cpu_stall && o_cpu_go && o_copy_done && !o_rom_req)
		else $error("copy end did not release cpu");
	a_no_boot_run: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r == ST_RESET && mode_s2_r == BOOT_NONE |=> !o_cpu_stall ##1 !o_rom_req)
		else $error("no boot did not start at once");
	a_mode_held: assert property (@(posedge i_clk) disable iff (dev_rst)
		state_r != ST_RESET && $past(state_r) != ST_RESET |-> $stable(mode_r))
		else $error("boot mode changed after sampling");
endmodule : boot_seq
`default_nettype wire

/* File: logic/boot_pkg.sv */
// Constants and types shared by the boot sequencer and the address decoder
package boot_pkg;
	// ============================================================
	// Boot mode codes on the strap pins
	localparam logic [1:0]  BOOT_NONE        = 2'h0;
	localparam logic [1:0]  BOOT_HOST        = 2'h1;
	localparam logic [1:0]  BOOT_EMIF        = 2'h2;
	localparam logic [1:0]  BOOT_MODE_RST    = 2'h0;
	// ============================================================
	// Boot copy
	localparam int          ROM_IMAGE_BYTES  = 1024;
	localparam int          BYTES_PER_WORD   = 4;
	localparam logic [31:0] ROM_BASE_ADDR    = 32'h9000_0000;
	localparam logic [31:0] CPU_START_ADDR   = 32'h0000_0000;
	localparam logic [31:0] COPY_DEST_ADDR   = 32'h0000_0000;
	// ============================================================
	// Address map
	localparam logic [31:0] INT_MEM_BASE     = 32'h0000_0000;
	localparam logic [31:0] INT_MEM_LAST     = 32'h0003_ffff;
	localparam logic [31:0] EMIF_CTRL_BASE   = 32'h0180_0000;
	localparam logic [31:0] EMIF_CTRL_LAST   = 32'h0183_ffff;
	localparam logic [31:0] EXT_MEM_BASE     = 32'h8000_0000;
	localparam logic [31:0] EXT_MEM_LAST     = 32'hbfff_ffff;
	localparam int          EXT_REGION_LSB   = 28;

	typedef enum logic [2:0] {
		REGION_NONE,
		REGION_INT_MEM,
		REGION_EMIF_CTRL,
		REGION_EXT_ZERO,
		REGION_EXT_ONE,
		REGION_EXT_TWO,
		REGION_EXT_THREE
	} region_t;
endpackage : boot_pkg

/* File: logic/addr_decode.sv */
// Registered top-level address decoder
`timescale 1ns/10ps
`default_nettype none
module addr_decode (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_valid,
	input  wire logic [31:0]       i_addr,
	output var  logic              o_valid,
	output var  boot_pkg::region_t o_region,
	output var  logic [31:0]       o_offset
);
	import boot_pkg::*;

	region_t     region_nxt;
	logic [31:0] offset_nxt;

	always_comb begin
		region_nxt = REGION_NONE;
		offset_nxt = 32'h0000_0000;
		if (i_addr <= INT_MEM_LAST) begin
			region_nxt = REGION_INT_MEM;
			offset_nxt = i_addr - INT_MEM_BASE;
		end else if (i_addr >= EMIF_CTRL_BASE && i_addr <= EMIF_CTRL_LAST) begin
			region_nxt = REGION_EMIF_CTRL;
			offset_nxt = i_addr - EMIF_CTRL_BASE;
		end else if (i_addr >= EXT_MEM_BASE && i_addr <= EXT_MEM_LAST) begin
			case (i_addr[EXT_REGION_LSB +: 2])
				2'h0: region_nxt = REGION_EXT_ZERO;
				2'h1: region_nxt = REGION_EXT_ONE;
				2'h2: region_nxt = REGION_EXT_TWO;
				default: region_nxt = REGION_EXT_THREE;
			endcase
			offset_nxt = {4'h0, i_addr[EXT_REGION_LSB-1:0]};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_valid  <= 1'b0;
			o_region <= REGION_NONE;
			o_offset <= 32'h0000_0000;
		end else begin
			o_valid  <= i_valid;
			o_region <= region_nxt;
			o_offset <= offset_nxt;
		end
	end
endmodule : addr_decode
`default_nettype wire

/* File: bench/boot_rom_model.sv */
// Byte-wide boot ROM answering the copy requests
`timescale 1ns/10ps
`default_nettype none
module boot_rom_model (
	input  wire logic        i_clk,
	input  wire logic        i_slow,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	output var  logic        o_ack,
	output var  logic [7:0]  o_data
);
	int unsigned tick = 0;
	initial begin
		o_ack = 1'b0;
		o_data = 8'h00;
	end
	// ============================================================
	// Answer on the falling edge, idle data toggles
	always @(negedge i_clk) begin
		tick <= tick + 1;
		if (i_req === 1'b1 && (!i_slow || tick % 3 == 0)) begin
			o_ack <= 1'b1;
			o_data <= i_addr[7:0] * 8'h3b + 8'h17;
		end else begin
			o_ack <= 1'b0;
			o_data <= ~o_data;
		end
	end
endmodule : boot_rom_model
`default_nettype wire

/* File: bench/boot_sequencer_address_decode_test.sv */
// Self-checking bench for the boot sequencer
`timescale 1ns/10ps
`default_nettype none
module boot_sequencer_address_decode_test;
	import boot_pkg::*;
	localparam int ROM_N = 16;
	logic i_clk, i_rst, i_reset_n, i_big_endian, i_hint_set, i_cpu_hint_clr;
	logic i_host_req, i_host_we, i_rom_ack, i_slow;
	logic [1:0] i_boot_mode;
	logic [31:0] i_host_addr, i_host_wdata;
	logic [7:0] i_rom_data;
	logic o_periph_rst, o_cpu_stall, o_cpu_go, o_hint_flag, o_cpu_int, o_bus_valid, o_bus_we;
	logic o_rom_req, o_rom_default_timing, o_mem_wr, o_copy_done;
	logic [31:0] o_cpu_start_addr, o_bus_offset, o_bus_wdata, o_rom_addr, o_mem_addr, o_mem_wdata;
	region_t o_bus_region;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n, k;
	logic [31:0] exp_q[$];
	logic [31:0] tbl[12] = '{32'h0, 32'h3_fffc, 32'h4_0000, 32'h0180_0010, 32'h0183_fffc, 32'h0184_0000,
		32'h8000_0004, 32'h9abc_0000, 32'ha000_0100, 32'hbfff_fffc, 32'hc000_0000, 32'h7fff_fffc};

	boot_seq #(.ROM_BYTES(ROM_N)) u_boot_seq (
		.i_clk(i_clk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_boot_mode(i_boot_mode),
		.i_big_endian(i_big_endian), .i_hint_set(i_hint_set), .i_cpu_hint_clr(i_cpu_hint_clr),
		.i_host_req(i_host_req), .i_host_we(i_host_we), .i_host_addr(i_host_addr), .i_host_wdata(i_host_wdata),
		.i_rom_ack(i_rom_ack), .i_rom_data(i_rom_data), .o_periph_rst(o_periph_rst), .o_cpu_stall(o_cpu_stall),
		.o_cpu_go(o_cpu_go), .o_cpu_start_addr(o_cpu_start_addr), .o_hint_flag(o_hint_flag), .o_cpu_int(o_cpu_int),
		.o_bus_valid(o_bus_valid), .o_bus_we(o_bus_we), .o_bus_region(o_bus_region), .o_bus_offset(o_bus_offset),
		.o_bus_wdata(o_bus_wdata), .o_rom_req(o_rom_req), .o_rom_addr(o_rom_addr),
		.o_rom_default_timing(o_rom_default_timing), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .o_copy_done(o_copy_done));
	boot_rom_model u_boot_rom_model (.i_clk(i_clk), .i_slow(i_slow), .i_req(o_rom_req),
		.i_addr(o_rom_addr), .o_ack(i_rom_ack), .o_data(i_rom_data));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// ============================================================
	// Shared checks
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wait_lim(input int lim, input string what);
		if (n >= lim) begin
			n_mismatch++;
			$display("ERROR %s expected done seen timeout", what);
			wrap_up();
		end
	endtask : wait_lim
	function automatic region_t exp_region(input logic [31:0] a);
		if (a <= 32'h0003_ffff) return REGION_INT_MEM;
		if (a >= 32'h0180_0000 && a <= 32'h0183_ffff) return REGION_EMIF_CTRL;
		case (a[31:28])
			4'h8: return REGION_EXT_ZERO;
			4'h9: return REGION_EXT_ONE;
			4'ha: return REGION_EXT_TWO;
			4'hb: return REGION_EXT_THREE;
			default: return REGION_NONE;
		endcase
	endfunction : exp_region
	task automatic host_check(input logic [31:0] a, input logic w, input logic [31:0] d);
		region_t r;
		logic [31:0] off;
		r = exp_region(a);
		off = (r == REGION_EMIF_CTRL) ? a - 32'h0180_0000 : (r == REGION_INT_MEM) ? a : {4'h0, a[27:0]};
		chk("bus_valid", 32'h1, {31'h0, o_bus_valid});
		chk("bus_region", 32'(r), 32'(o_bus_region));
		if (r != REGION_NONE) chk("bus_offset", off, o_bus_offset);
		chk("bus_we", {31'h0, w}, {31'h0, o_bus_we});
		if (w) chk("bus_wdata", d, o_bus_wdata);
	endtask : host_check
	task automatic do_reset(input logic [1:0] mode, input logic big);
		@(negedge i_clk);
		i_rst = 1'b1;
		i_reset_n = 1'b0;
		i_boot_mode = mode;
		i_big_endian = big;
		repeat (10) @(negedge i_clk);
		chk("cpu_stall", 32'h1, {31'h0, o_cpu_stall});
		chk("periph_rst", 32'h1, {31'h0, o_periph_rst});
		i_rst = 1'b0;
		i_reset_n = 1'b1;
	endtask : do_reset
	function automatic logic [7:0] rb(input int a);
		return 8'(a) * 8'h3b + 8'h17;
	endfunction : rb
	// ============================================================
	// Copy monitor against the expected word queue
	always @(negedge i_clk) begin
		if (o_mem_wr === 1'b1) begin
			if (exp_q.size() == 0) chk("mem_wr_extra", 32'h0, 32'h1);
			else begin
				chk("mem_addr", 32'(k * 4), o_mem_addr);
				chk("mem_wdata", exp_q.pop_front(), o_mem_wdata);
				k++;
			end
		end
	end
	task automatic rom_boot(input logic big, input logic slow);
		do_reset(BOOT_EMIF, big);
		i_slow = slow;
		k = 0;
		for (int w = 0; w < ROM_N; w += 4) begin
			if (big) exp_q.push_back({rb(w), rb(w + 1), rb(w + 2), rb(w + 3)});
			else exp_q.push_back({rb(w + 3), rb(w + 2), rb(w + 1), rb(w)});
		end
		for (n = 0; n < 10 && o_rom_req !== 1'b1; n++) @(negedge i_clk);
		wait_lim(10, "rom_req");
		chk("rom_addr", 32'h9000_0000, o_rom_addr);
		chk("rom_timing", 32'h1, {31'h0, o_rom_default_timing});
		i_boot_mode = BOOT_NONE;
		i_hint_set = 1'b1;
		@(negedge i_clk);
		i_hint_set = 1'b0;
		@(negedge i_clk);
		chk("stall_copy", 32'h1, {31'h0, o_cpu_stall});
		for (n = 0; n < 300 && o_copy_done !== 1'b1; n++) @(negedge i_clk);
		wait_lim(300, "copy_done");
		chk("go", 32'h1, {31'h0, o_cpu_go});
		chk("stall", 32'h0, {31'h0, o_cpu_stall});
		chk("start", 32'h0, o_cpu_start_addr);
		@(negedge i_clk);
		chk("words", ROM_N / 4, k);
		$display("test rom_boot big=%0d slow=%0d done", big, slow);
	endtask : rom_boot
	// ============================================================
	// Main sequence
	initial begin
		{i_rst, i_reset_n, i_boot_mode, i_big_endian, i_hint_set, i_cpu_hint_clr} = 7'h40;
		{i_host_req, i_host_we, i_host_addr, i_host_wdata, i_slow} = '0;
		void'($urandom(69828));
		do_reset(BOOT_HOST, 1'b0);
		repeat (8) @(negedge i_clk);
		chk("stall_host", 32'h1, {31'h0, o_cpu_stall});
		chk("periph_rst", 32'h0, {31'h0, o_periph_rst});
		for (int i = 0; i <= 40; i++) begin
			@(negedge i_clk);
			if (i > 0) host_check(i_host_addr, i_host_we, i_host_wdata);
			i_host_req = (i < 40);
			i_host_addr = (i < 12) ? tbl[i] : $urandom;
			i_host_we = 1'($urandom);
			i_host_wdata = $urandom;
		end
		chk("stall_host", 32'h1, {31'h0, o_cpu_stall});
		i_hint_set = 1'b1;
		@(negedge i_clk);
		i_hint_set = 1'b0;
		chk("go", 32'h1, {31'h0, o_cpu_go});
		chk("stall", 32'h0, {31'h0, o_cpu_stall});
		chk("start", 32'h0, o_cpu_start_addr);
		chk("cpu_int", 32'h0, {31'h0, o_cpu_int});
		chk("flag", 32'h1, {31'h0, o_hint_flag});
		chk("bus_idle", 32'h0, {31'h0, o_bus_valid});
		i_hint_set = 1'b1;
		@(negedge i_clk);
		i_hint_set = 1'b0;
		@(negedge i_clk);
		chk("cpu_int_held", 32'h0, {31'h0, o_cpu_int});
		i_cpu_hint_clr = 1'b1;
		@(negedge i_clk);
		i_cpu_hint_clr = 1'b0;
		chk("flag_clr", 32'h0, {31'h0, o_hint_flag});
		i_hint_set = 1'b1;
		@(negedge i_clk);
		i_hint_set = 1'b0;
		chk("cpu_int", 32'h1, {31'h0, o_cpu_int});
		$display("test host_boot done");
		rom_boot(1'b0, 1'b0);
		rom_boot(1'b1, 1'b1);
		foreach (tbl[m]) if (m < 2) begin
			do_reset(m ? 2'h3 : BOOT_NONE, 1'b0);
			for (n = 0; n < 8 && o_cpu_stall !== 1'b0; n++) @(negedge i_clk);
			wait_lim(8, "no_boot_stall");
			chk("go", 32'h1, {31'h0, o_cpu_go});
			chk("start", 32'h0, o_cpu_start_addr);
			chk("rom_req", 32'h0, {31'h0, o_rom_req});
			$display("test no_boot %0d done", m);
		end
		wrap_up();
	end
endmodule : boot_sequencer_address_decode_test
`default_nettype wire
